// ===== verif/serial_node_model.sv
module serial_node_model (
  input wire logic hclk,
  input wire logic txd,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line is pulled up, so it rests high between frames.
  initial line_out = 1'b1;
  task automatic send(input logic [10:0] bits, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (bt) @(posedge hclk);
    end
    line_out <= 1'b1;
  endtask
  // Samples on the falling clock edge to stay clear of the pin flops.
  task automatic catch_frame(input int n, input int bt, output logic [10:0] bits, output logic ok);
    int k;
    bits = '0;
    for (k = 0; k < 4000 && txd !== 1'b0; k++) @(negedge hclk);
    ok = (txd === 1'b0);
    repeat (bt / 2) @(negedge hclk);
    for (int i = 0; i < n && ok; i++) begin
      bits[i] = txd;
      if (i != n - 1) repeat (bt) @(negedge hclk);
    end
  endtask
endmodule

// ===== verif/serial_port_core_assertions.sv
module serial_port_core_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rxd_oe,
  input wire logic txd,
  input wire logic serial_irq,
  input wire logic serial_irq_top
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic tk;
  logic rd_reg;
  logic [3:0] since_wr_reg;
  assign tk = hsel && htrans[1] && hready && hreadyout;
  // Tracks the software writes that alone may clear the sticky flags.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg <= 1'b0;
      since_wr_reg <= 4'hf;
    end else begin
      rd_reg <= tk ? !hwrite : (hreadyout ? 1'b0 : rd_reg);
      since_wr_reg <= (tk && hwrite) ? 4'h0 : since_wr_reg + {3'h0, since_wr_reg != 4'hf};
    end
  end
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_wait;
    tk |=> !hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait state after transfer");
  property p_wait_end;
    $fell(hreadyout) |-> ##[1:1000] hreadyout;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("bus stalled too long");
  property p_top;
    serial_irq_top |-> serial_irq;
  endproperty
  a_top: assert property (p_top) else $error("top level without request");
  property p_irq_fall;
    $fell(serial_irq) |-> since_wr_reg <= 4'h4;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped without write");
  property p_rdata_hold;
    $changed(hrdata) |-> $past(rd_reg);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_shift_clk;
    rxd_oe && $fell(txd) |-> (!txd)[*6] ##1 txd;
  endproperty
  a_shift_clk: assert property (p_shift_clk) else $error("shift clock not six low");
  property p_reset_idle;
    $rose(hresetn) |-> txd && !rxd_oe && !serial_irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
  c_read: cover property (tk && !hwrite);
  c_top: cover property ($rose(serial_irq_top));
  c_stall: cover property ((!hreadyout)[*4]);
endmodule

bind serial_port_core serial_port_core_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .rxd_oe(rxd_oe), .txd(txd), .serial_irq(serial_irq), .serial_irq_top(serial_irq_top));

// ===== verif/serial_port_core_bench.sv
`include "serial_port_regs.vh"
module serial_port_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIM = 3000;
  localparam logic [9:0] CT = `CONTROL_IDX;
  localparam logic [9:0] DB = `DATA_BUFFER_IDX;
  localparam logic [9:0] IE = `IRQ_ENABLE_IDX;
  localparam logic [9:0] PR = `TOP_PRIORITY_IDX;
  localparam logic [9:0] CF = `PORT_CONFIG_IDX;
  typedef struct {logic [9:0] idx; logic [31:0] w; logic [31:0] e;} row_t;
  logic hclk, hresetn, hsel, hwrite, hrdy, hresp, rxd_out, rxd_oe, txd, irq, irq_top, line, ok, pt;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [10:0] fr;
  int fail_count, n_checks, nb;
  row_t rows [5] = '{'{IE, 32'h0000_0090, 32'h0000_0090}, '{`SLAVE_ADDRESS_IDX, 32'h0000_005a, 32'h0000_005a},
    '{`ADDRESS_MASK_IDX, 32'h0000_00ff, 32'h0000_00ff}, '{PR, 32'h0000_0000, 32'h0000_0080},
    '{10'h0a0, 32'h0000_0055, 32'h0000_0000}};
  serial_port_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
    .hresp(hresp), .rxd_in(rxd_oe ? rxd_out : line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
    .serial_irq(irq), .serial_irq_top(irq_top));
  serial_node_model node (.hclk(hclk), .txd(txd), .line_out(line));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wt();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hrdy !== 1'b1 && k < LIM);
    if (hrdy !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic xf(input logic [9:0] i, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, i, 2'b00};
    hwrite <= w;
    wt();
    htrans <= 2'b00;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic rc(input logic [9:0] i, input logic [31:0] e);
    xf(i, 1'b0, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic tx(input logic [7:0] d, input int n, input int bt, input logic [10:0] e);
    fork
      xf(DB, 1'b1, {24'h0, d});
      node.catch_frame(n, bt, fr, ok);
    join
    @(posedge hclk);
    chk({ok, fr}, {1'b1, e});
  endtask
  // Leaves the control register in q once the frame has landed.
  task automatic rx(input logic [10:0] f, input int n);
    node.send(f, n, 8);
    repeat (8) @(posedge hclk);
    xf(CT, 1'b0, 32'h0000_0000);
  endtask
  function automatic logic [10:0] fm(input logic [7:0] d, input logic n9, input logic h9, input logic sp);
    return h9 ? {sp, n9, d, 1'b0} : {1'b0, sp, d, 1'b0};
  endfunction
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(CT, 32'h0000_0000);
    rc(PR, 32'h0000_0080);
    rc(`BAUD_DIVISOR_IDX, 32'h0000_0364);
    foreach (rows[i]) begin
      xf(rows[i].idx, 1'b1, rows[i].w);
      rc(rows[i].idx, rows[i].e);
    end
    $display("registers done");
    xf(`BAUD_DIVISOR_IDX, 1'b1, 32'h0000_0008);
    xf(CT, 1'b1, 32'h0000_0050);
    tx(8'ha5, 10, 8, fm(8'ha5, 1'b0, 1'b0, 1'b1));
    rc(CT, 32'h0000_0052);
    rx(fm(8'h3c, 1'b0, 1'b0, 1'b1), 10);
    chk(q, 32'h0000_0057);
    rc(DB, 32'h0000_003c);
    for (int i = 0; i < 4; i++) begin
      xf(IE, 1'b1, {24'h0, i[1], 2'b00, i[0], 4'h0});
      repeat (3) @(posedge hclk);
      chk(irq, i == 3);
    end
    xf(PR, 1'b1, 32'h0000_0010);
    repeat (3) @(posedge hclk);
    chk(irq_top, 1'b1);
    xf(CT, 1'b1, 32'h0000_0040);
    repeat (3) @(posedge hclk);
    chk(irq, 1'b0);
    rx(fm(8'h11, 1'b0, 1'b0, 1'b1), 10);
    chk(q, 32'h0000_0040);
    $display("mode 1 done");
    xf(CT, 1'b1, 32'h0000_00d8);
    tx(8'h5a, 11, 8, fm(8'h5a, 1'b1, 1'b1, 1'b1));
    rx(fm(8'hc3, 1'b1, 1'b1, 1'b1), 11);
    chk(q, 32'h0000_00df);
    rc(DB, 32'h0000_00c3);
    xf(CT, 1'b1, 32'h0000_00f0);
    rx(fm(8'h5a, 1'b0, 1'b1, 1'b1), 11);
    chk(q[0], 1'b0);
    rx(fm(8'h5b, 1'b1, 1'b1, 1'b1), 11);
    chk(q[0], 1'b0);
    rx(fm(8'h5a, 1'b1, 1'b1, 1'b1), 11);
    chk(q[0], 1'b1);
    xf(CT, 1'b1, 32'h0000_0080);
    tx(8'h96, 11, 64, fm(8'h96, 1'b0, 1'b1, 1'b1));
    xf(CT, 1'b1, 32'h0000_0000);
    // The shift clock rises mid-bit, so each data bit is taken on its rising edge.
    fr = '0;
    nb = 0;
    pt = 1'b1;
    fork
      xf(DB, 1'b1, 32'h0000_0081);
      for (int k = 0; k < LIM && nb < 8; k++) begin
        @(negedge hclk);
        if (rxd_oe && txd && !pt) begin
          fr[nb] = rxd_out;
          nb++;
        end
        pt = txd;
      end
    join
    chk(fr[7:0], 8'h81);
    repeat (12) @(posedge hclk);
    rc(CT, 32'h0000_0002);
    xf(CT, 1'b1, 32'h0000_0010);
    repeat (8 * 12 + 12) @(posedge hclk);
    rc(CT, 32'h0000_0011);
    rc(DB, 32'h0000_00ff);
    xf(CT, 1'b1, 32'h0000_0050);
    xf(CF, 1'b1, 32'h0000_0001);
    rx(fm(8'h44, 1'b0, 1'b0, 1'b0), 10);
    chk(q[7], 1'b1);
    xf(CF, 1'b1, 32'h0000_0000);
    $display("modes done");
    xf(CT, 1'b1, 32'h0000_0050);
    // Ten writes overrun the eight-deep buffer behind the busy transmitter, so the last must stall.
    fork
      for (int i = 0; i < 10; i++) xf(DB, 1'b1, 32'h0000_0011 * i);
      for (int i = 0; i < 10; i++) begin
        node.catch_frame(10, 8, fr, ok);
        chk({ok, fr}, {1'b1, fm(8'h11 * i, 1'b0, 1'b0, 1'b1)});
      end
    join
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(CT, 32'h0000_0000);
    rc(`BAUD_DIVISOR_IDX, 32'h0000_0364);
    $display("buffer and reset done");
    summarize();
  end
endmodule

// ===== verilog/data_fifo.v
module data_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam integer DEPTH_INT = DEPTH;
  localparam integer LAST_INT = DEPTH - 1;
  localparam [AW:0] FULL = DEPTH_INT[AW:0];
  localparam [AW-1:0] LAST = LAST_INT[AW-1:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != FULL);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push & !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ===== verilog/serial_port_core.v
`include "serial_port_regs.vh"

// Behaviour
// - Shift mode clocks at oscillator/12 unless multiprocessor.
// - Receive only while receive enable set.
// - Eleven-bit modes send software ninth bit.
// - Eleven-bit modes store received ninth bit.
// - Ten-bit mode stores stop bit as ninth.
// - Transmit done at stop start, sticky.
// - Receive done mid stop bit, sticky.
// - Data location: read receive, write transmit.
// - Interrupt needs serial and global enable.
// - Top priority bit raises serial interrupt level.
// - Two mode bits select four modes.
// - Multiprocessor suppresses receive done on mismatch in eleven-bit modes, on bad stop in ten-bit mode.
// - Masked address match gates the interrupt.
// - Framing error flag on bad stop.
module serial_port_core (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire rxd_in,
  output reg rxd_out,
  output reg rxd_oe,
  output reg txd,
  output reg serial_irq,
  output reg serial_irq_top
);
  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;
  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_FRAME = 2'b10;
  localparam RX_SHIFT = 2'b11;
  localparam [7:0] CONTROL_INIT = `CONTROL_RESET;

  reg pend_reg;
  reg pend_write_reg;
  reg [9:0] pend_idx_reg;
  reg mode_high_reg;
  reg mode_low_reg;
  reg multiproc_enable_reg;
  reg rx_enable_reg;
  reg tx_ninth_bit_reg;
  reg rx_ninth_bit_reg;
  reg tx_done_flag_reg;
  reg rx_done_flag_reg;
  reg framing_error_flag_reg;
  reg framing_error_select_reg;
  reg [7:0] rx_data_reg;
  reg [7:0] irq_enable_reg;
  reg [7:0] slave_address_reg;
  reg [7:0] slave_address_mask_reg;
  reg [6:0] top_priority_reg;
  reg [15:0] baud_reg;
  reg [31:0] rd_value;
  reg tx_state_reg;
  reg [10:0] tx_frame_reg;
  reg [3:0] tx_left_reg;
  reg [15:0] tx_timer_reg;
  reg [1:0] rx_state_reg;
  reg [9:0] rx_sr_reg;
  reg [3:0] rx_left_reg;
  reg [15:0] rx_timer_reg;
  reg rx_meta_reg;
  reg rx_sync_reg;
  reg rx_sync2_reg;
  reg rx_level_reg;
  reg rx_prev_reg;

  wire take = hsel & htrans[1] & hready & hreadyout;
  wire addr_hit = (haddr[31:12] == 20'h0_0000);
  wire data_sel = pend_write_reg & (pend_idx_reg == `DATA_BUFFER_IDX);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_out_ready = (tx_state_reg == TX_IDLE);
  // A transmit write into a full buffer holds the bus until a slot frees.
  wire stall = pend_reg & data_sel & !fifo_in_ready;
  wire wr_en = pend_reg & pend_write_reg & !stall;
  wire ctl_wr = wr_en & (pend_idx_reg == `CONTROL_IDX);
  wire fifo_in_valid = pend_reg & data_sel;

  // Mode decode: 00 shift, 01 ten-bit, 10 fixed eleven-bit, 11 eleven-bit.
  wire mode0 = !mode_high_reg & !mode_low_reg;
  wire mode1 = !mode_high_reg & mode_low_reg;
  wire mode2 = mode_high_reg & !mode_low_reg;
  wire [15:0] baud_eff = (baud_reg < `BAUD_DIVISOR_MIN) ? `BAUD_DIVISOR_MIN : baud_reg;
  wire [15:0] shift_div = multiproc_enable_reg ? `SHIFT_DIVIDE_FAST : `SHIFT_DIVIDE;
  wire [15:0] bit_period = mode0 ? shift_div : (mode2 ? `FIXED_DIVIDE : baud_eff);
  wire [15:0] bit_last = bit_period - 16'h0001;
  wire [15:0] bit_half = {1'b0, bit_period[15:1]};

  wire tx_tick = (tx_state_reg == TX_SEND) & (tx_timer_reg >= bit_last);
  wire tx_done_set = tx_tick & (mode0 ? (tx_left_reg == 4'h1) : (tx_left_reg == 4'h2));
  wire tx_sclk = (tx_timer_reg >= bit_half);

  wire rx_tick = (rx_timer_reg >= bit_last);
  wire rx_sclk = (rx_timer_reg >= bit_half);
  wire rx_last = rx_tick & (rx_left_reg == 4'h1);
  wire [7:0] rx_byte = mode1 ? rx_sr_reg[9:2] : rx_sr_reg[8:1];
  wire rx_ninth_in = mode1 ? rx_level_reg : rx_sr_reg[9];
  wire rx_stop = rx_level_reg;
  wire addr_match = (((rx_byte ^ slave_address_reg) & slave_address_mask_reg) == 8'h00);
  // A frame is kept only if the receive done flag is clear and the filter passes.
  wire mp_pass = mode1 ? (!multiproc_enable_reg | rx_stop)
               : (!multiproc_enable_reg | (rx_ninth_in & addr_match));
  wire frame_end = (rx_state_reg == RX_FRAME) & rx_last;
  wire shift_end = (rx_state_reg == RX_SHIFT) & rx_last;
  wire rx_accept = frame_end & !rx_done_flag_reg & mp_pass;
  wire rx_done_set = rx_accept | (shift_end & !rx_done_flag_reg);
  wire fe_set = frame_end & !rx_stop;

  data_fifo #(.WIDTH(8), .DEPTH(8)) tx_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(hwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always @* begin
    rd_value = 32'h0000_0000;
    case (pend_idx_reg)
      `CONTROL_IDX: rd_value[7:0] = {framing_error_select_reg ? framing_error_flag_reg : mode_high_reg,
                                     mode_low_reg, multiproc_enable_reg, rx_enable_reg,
                                     tx_ninth_bit_reg, rx_ninth_bit_reg,
                                     tx_done_flag_reg, rx_done_flag_reg};
      `DATA_BUFFER_IDX: rd_value[7:0] = rx_data_reg;
      `IRQ_ENABLE_IDX: rd_value[7:0] = irq_enable_reg;
      `SLAVE_ADDRESS_IDX: rd_value[7:0] = slave_address_reg;
      `TOP_PRIORITY_IDX: rd_value[7:0] = {1'b1, top_priority_reg};
      `ADDRESS_MASK_IDX: rd_value[7:0] = slave_address_mask_reg;
      `PORT_CONFIG_IDX: rd_value[`CFG_FE_SELECT] = framing_error_select_reg;
      `BAUD_DIVISOR_IDX: rd_value[15:0] = baud_reg;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // Each transfer takes one wait state, more while a transmit write stalls; the data phase completes a cycle later.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 1'b0;
      pend_write_reg <= 1'b0;
      pend_idx_reg <= 10'h000;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (take) begin
        pend_reg <= 1'b1;
        pend_write_reg <= hwrite;
        pend_idx_reg <= addr_hit ? haddr[11:2] : 10'h3ff;
        hreadyout <= 1'b0;
      end else if (pend_reg & !stall) begin
        pend_reg <= 1'b0;
        hreadyout <= 1'b1;
        if (!pend_write_reg) begin
          hrdata <= rd_value;
        end
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {mode_high_reg, mode_low_reg, multiproc_enable_reg, rx_enable_reg} <= CONTROL_INIT[7:4];
      tx_ninth_bit_reg <= 1'b0;
      rx_ninth_bit_reg <= 1'b0;
      tx_done_flag_reg <= 1'b0;
      rx_done_flag_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      framing_error_select_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      irq_enable_reg <= `IRQ_ENABLE_RESET;
      slave_address_reg <= `SLAVE_ADDRESS_RESET;
      slave_address_mask_reg <= `ADDRESS_MASK_RESET;
      top_priority_reg <= `TOP_PRIORITY_RESET;
      baud_reg <= `BAUD_DIVISOR_RESET;
    end else begin
      if (ctl_wr) begin
        if (!framing_error_select_reg) begin
          mode_high_reg <= hwdata[`CTL_MODE_HIGH];
        end
        mode_low_reg <= hwdata[`CTL_MODE_LOW];
        multiproc_enable_reg <= hwdata[`CTL_MULTIPROC];
        rx_enable_reg <= hwdata[`CTL_RX_ENABLE];
        tx_ninth_bit_reg <= hwdata[`CTL_TX_NINTH];
      end
      // Hardware sets win over a software write in the same cycle.
      tx_done_flag_reg <= (ctl_wr ? hwdata[`CTL_TX_DONE] : tx_done_flag_reg) | tx_done_set;
      rx_done_flag_reg <= (ctl_wr ? hwdata[`CTL_RX_DONE] : rx_done_flag_reg) | rx_done_set;
      framing_error_flag_reg <= ((ctl_wr & framing_error_select_reg) ? hwdata[`CTL_MODE_HIGH]
                                 : framing_error_flag_reg) | fe_set;
      if (rx_accept) begin
        rx_data_reg <= rx_byte;
        rx_ninth_bit_reg <= rx_ninth_in;
      end else if (shift_end & !rx_done_flag_reg) begin
        rx_data_reg <= {rx_level_reg, rx_sr_reg[9:3]};
      end else if (ctl_wr) begin
        rx_ninth_bit_reg <= hwdata[`CTL_RX_NINTH];
      end
      if (wr_en) begin
        case (pend_idx_reg)
          `IRQ_ENABLE_IDX: irq_enable_reg <= hwdata[7:0];
          `SLAVE_ADDRESS_IDX: slave_address_reg <= hwdata[7:0];
          `TOP_PRIORITY_IDX: top_priority_reg <= hwdata[6:0];
          `ADDRESS_MASK_IDX: slave_address_mask_reg <= hwdata[7:0];
          `PORT_CONFIG_IDX: framing_error_select_reg <= hwdata[`CFG_FE_SELECT];
          `BAUD_DIVISOR_IDX: baud_reg <= hwdata[15:0];
          default: baud_reg <= baud_reg;
        endcase
      end
    end
  end

  // Transmitter: frames are shifted out LSB first from the buffer.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= TX_IDLE;
      tx_frame_reg <= 11'h7ff;
      tx_left_reg <= 4'h0;
      tx_timer_reg <= 16'h0000;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_timer_reg <= 16'h0000;
          if (fifo_out_valid) begin
            if (mode0) begin
              tx_frame_reg <= {3'b111, fifo_out_data};
              tx_left_reg <= `SHIFT_BITS;
            end else if (mode1) begin
              tx_frame_reg <= {2'b11, fifo_out_data, 1'b0};
              tx_left_reg <= `TEN_BIT_FRAME;
            end else begin
              tx_frame_reg <= {1'b1, tx_ninth_bit_reg, fifo_out_data, 1'b0};
              tx_left_reg <= `ELEVEN_BIT_FRAME;
            end
            tx_state_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_tick) begin
            tx_timer_reg <= 16'h0000;
            tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
            if (tx_left_reg == 4'h1) begin
              tx_state_reg <= TX_IDLE;
            end
          end else begin
            tx_timer_reg <= tx_timer_reg + 16'h0001;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // The line is filtered: a level counts once the second and third stages agree.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_sync2_reg <= 1'b1;
      rx_level_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rxd_in;
      rx_sync_reg <= rx_meta_reg;
      rx_sync2_reg <= rx_sync_reg;
      if (rx_sync_reg == rx_sync2_reg) begin
        rx_level_reg <= rx_sync2_reg;
      end
      rx_prev_reg <= rx_level_reg;
    end
  end

  // Receiver: dropping the enable aborts any frame in progress.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_reg <= RX_IDLE;
      rx_sr_reg <= 10'h000;
      rx_left_reg <= 4'h0;
      rx_timer_reg <= 16'h0000;
    end else if (!rx_enable_reg) begin
      rx_state_reg <= RX_IDLE;
      rx_timer_reg <= 16'h0000;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_timer_reg <= 16'h0000;
          if (mode0) begin
            // Shift-mode reception waits for the shared data line to be free.
            if (!rx_done_flag_reg & (tx_state_reg == TX_IDLE) & !fifo_out_valid) begin
              rx_state_reg <= RX_SHIFT;
              rx_left_reg <= `SHIFT_BITS;
            end
          end else if (rx_prev_reg & !rx_level_reg) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (rx_timer_reg >= bit_half) begin
            rx_timer_reg <= 16'h0000;
            rx_left_reg <= mode1 ? (`TEN_BIT_FRAME - 4'h1) : (`ELEVEN_BIT_FRAME - 4'h1);
            rx_state_reg <= rx_level_reg ? RX_IDLE : RX_FRAME;
          end else begin
            rx_timer_reg <= rx_timer_reg + 16'h0001;
          end
        end
        RX_FRAME, RX_SHIFT: begin
          if (rx_tick) begin
            rx_timer_reg <= 16'h0000;
            rx_sr_reg <= {rx_level_reg, rx_sr_reg[9:1]};
            rx_left_reg <= rx_left_reg - 4'h1;
            if (rx_left_reg == 4'h1) begin
              rx_state_reg <= RX_IDLE;
            end
          end else begin
            rx_timer_reg <= rx_timer_reg + 16'h0001;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Pins and interrupt leave from flops; the extra stage delays pins equally.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      serial_irq <= 1'b0;
      serial_irq_top <= 1'b0;
    end else begin
      if (mode0) begin
        txd <= (tx_state_reg == TX_SEND) ? tx_sclk
             : ((rx_state_reg == RX_SHIFT) ? rx_sclk : 1'b1);
      end else begin
        txd <= (tx_state_reg == TX_SEND) ? tx_frame_reg[0] : 1'b1;
      end
      rxd_out <= tx_frame_reg[0];
      rxd_oe <= mode0 & (tx_state_reg == TX_SEND);
      serial_irq <= irq_enable_reg[`IE_GLOBAL] & irq_enable_reg[`IE_SERIAL]
                    & (tx_done_flag_reg | rx_done_flag_reg);
      serial_irq_top <= irq_enable_reg[`IE_GLOBAL] & irq_enable_reg[`IE_SERIAL]
                        & top_priority_reg[`PRI_SERIAL_TOP]
                        & (tx_done_flag_reg | rx_done_flag_reg);
    end
  end
endmodule

// ===== verilog/serial_port_regs.vh
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define CONTROL_IDX 10'h098
`define DATA_BUFFER_IDX 10'h099
`define IRQ_ENABLE_IDX 10'h0a8
`define SLAVE_ADDRESS_IDX 10'h0a9
`define TOP_PRIORITY_IDX 10'h0b8
`define ADDRESS_MASK_IDX 10'h0b9
`define PORT_CONFIG_IDX 10'h0c8
`define BAUD_DIVISOR_IDX 10'h0c9

// Serial control field positions.
`define CTL_MODE_HIGH 7
`define CTL_MODE_LOW 6
`define CTL_MULTIPROC 5
`define CTL_RX_ENABLE 4
`define CTL_TX_NINTH 3
`define CTL_RX_NINTH 2
`define CTL_TX_DONE 1
`define CTL_RX_DONE 0

// Interrupt enable and priority field positions.
`define IE_GLOBAL 7
`define IE_SERIAL 4
`define PRI_SERIAL_TOP 4
`define PRI_UNUSED_BIT 7

// Port configuration field positions.
`define CFG_FE_SELECT 0

// Reset values.
`define CONTROL_RESET 8'h00
`define IRQ_ENABLE_RESET 8'h00
`define SLAVE_ADDRESS_RESET 8'h00
`define ADDRESS_MASK_RESET 8'h00
`define TOP_PRIORITY_RESET 7'h00
`define BAUD_DIVISOR_RESET 16'h0364

// Timing: oscillator cycles per serial bit.
`define SHIFT_DIVIDE 16'h000c
`define SHIFT_DIVIDE_FAST 16'h0004
`define FIXED_DIVIDE 16'h0040
`define BAUD_DIVISOR_MIN 16'h0002

// Frame lengths in bit times, counting the start bit where there is one.
`define SHIFT_BITS 4'h8
`define TEN_BIT_FRAME 4'ha
`define ELEVEN_BIT_FRAME 4'hb

`endif
